/* design/esa_map.vh */
// offsets, field positions, reset values and timing for the eight-port serial adapter
`ifndef ESA_MAP_VH
`define ESA_MAP_VH
`define ESA_REG_DATA 3'h0
`define ESA_REG_IER 3'h1
`define ESA_REG_IIR 3'h2
`define ESA_REG_LCR 3'h3
`define ESA_REG_MCR 3'h4
`define ESA_REG_LSR 3'h5
`define ESA_REG_MSR 3'h6
`define ESA_REG_SCR 3'h7
`define ESA_ARB_ADDR 16'h0130
`define ESA_LCR_RST 8'h03
`define ESA_MCR_RST 5'h08
`define ESA_DIV_RST 16'h0001
`define ESA_LCR_DLAB 7
`define ESA_LCR_STB 2
`define ESA_LCR_PEN 3
`define ESA_LCR_EPS 4
`define ESA_MCR_POL 3
`define ESA_IER_RDA 0
`define ESA_IER_THR 1
`define ESA_IER_LSR 2
`define ESA_IIR_NONE 4'h1
`define ESA_IIR_THR 4'h2
`define ESA_IIR_RDA 4'h4
`define ESA_IIR_LSR 4'h6
`define ESA_STOP_1 6'h10
`define ESA_STOP_15 6'h18
`define ESA_STOP_2 6'h20
`define ESA_REF_KHZ 15'h3000
`define ESA_CLK_KHZ 15'h61a8
`endif

/* design/esa_adapter.v */
// eight-port asynchronous serial adapter: four dual channel controllers plus interrupt logic
//
// Notes on behaviour
// - host reaches channel by 3-bit address, bytes
// - transmitter serialises bytes, optional trailing parity
// - receiver deserialises; parity checked only when enabled
// - fifo mode buffers sixteen characters each way
// - every character framed by start and stop bits
// - bit timing derived from 12.288 MHz reference
// - transmit and receive run independently, full duplex
// - four dual controllers give the eight ports
// - character length 5, 6, 7 or 8 bits
// - parity even, odd or none
// - one, one and half, or two stop bits
// - per-channel interrupt enables and line error flags
// - fixed priority, port 0 highest, 7 lowest
// - winning port info placed in arbitration register
// - one read gives adapter, port, interrupt type
// - only one of eight request lines driven
// - request pulls shared line low, else released
// - adapter number lets eight adapters share arbitration
// - modem-control bit 3: 1 normal, 0 inverted polarity
// - mark is binary one, space binary zero
// - each dual controller holds two independent channels
// - divisor covers 50 to 38400 bit/s
`include "esa_map.vh"
`timescale 1ns/1ns
`default_nettype none

module esa_dual_ctl #(
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_ref_tick,
  input wire [1:0] i_sel,
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [1:0] i_rxd,
  output wire [1:0] o_txd,
  output wire [15:0] o_rdata,
  output wire [1:0] o_pend,
  output wire [7:0] o_code
);
  genvar c;
  // two independent channels per controller
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_ch
      reg [7:0] lcr_ff, scr_ff, tsh_ff, rsh_ff;
      reg [3:0] ier_ff, err_ff;
      reg [4:0] mcr_ff;
      reg [15:0] div_ff, bcnt_ff;
      reg fen_ff, tl_ff, tpar_ff, txd_ff, rs1_ff, rs2_ff, rpe_ff, rpb_ff;
      reg [7:0] txm_ff [0:(1<<AW)-1];
      reg [7:0] rxm_ff [0:(1<<AW)-1];
      reg [AW-1:0] twp_ff, trp_ff, rwp_ff, rrp_ff;
      reg [AW:0] tcnt_ff, rcnt_ff;
      reg [2:0] tst_ff, rxs_ff, tbit_ff, rbit_ff;
      reg [5:0] tsub_ff, rsub_ff;
      reg [7:0] rdata;
      reg [3:0] code;
      wire wr = i_wr & i_sel[c];
      wire rd = i_rd & i_sel[c];
      wire dlab = lcr_ff[`ESA_LCR_DLAB];
      wire [AW:0] lim = fen_ff ? {1'b1, {AW{1'b0}}} : {{AW{1'b0}}, 1'b1};
      wire tick = i_ref_tick & (bcnt_ff == 16'h0000);
      wire [2:0] nlast = {1'b1, lcr_ff[1:0]};
      wire [7:0] mask = 8'hff >> (~lcr_ff[1:0]);
      wire [5:0] stopt = !lcr_ff[`ESA_LCR_STB] ? `ESA_STOP_1 :
        (lcr_ff[1:0] == 2'h0) ? `ESA_STOP_15 : `ESA_STOP_2;
      wire rl = rs2_ff ^ ~mcr_ff[`ESA_MCR_POL];
      wire push_t = wr & (i_addr == `ESA_REG_DATA) & !dlab & (tcnt_ff < lim);
      wire pop_r = rd & (i_addr == `ESA_REG_DATA) & !dlab & (rcnt_ff != 0);
      wire fcr_wr = wr & (i_addr == `ESA_REG_IIR);
      wire tx_go = tick & (tst_ff == 3'h0) & (tcnt_ff != 0);
      wire rx_done = tick & (rxs_ff == 3'h4) & (rsub_ff == 6'h00);
      wire [7:0] rdat = rsh_ff >> (~lcr_ff[1:0]);
      wire rfull = (rcnt_ff >= lim);
      wire lsr_rd = rd & (i_addr == `ESA_REG_LSR);
      wire [7:0] tword = txm_ff[trp_ff] & mask;
      wire tpar = (^tword) ^ ~lcr_ff[`ESA_LCR_EPS];
      wire rpar = (^rdat) ^ ~lcr_ff[`ESA_LCR_EPS];
      // error set: oe, pe, fe, bi
      wire [3:0] eset = {4{rx_done}} &
        {(rdat == 8'h00) & !rl & !rpb_ff, !rl, rpe_ff, rfull};
      wire ie_l = ier_ff[`ESA_IER_LSR] & (|err_ff);
      wire ie_r = ier_ff[`ESA_IER_RDA] & (rcnt_ff != 0);
      wire ie_t = ier_ff[`ESA_IER_THR] & (tcnt_ff == 0);
      // interrupt identification, line status first
      always @*
      begin
        if (ie_l)
          code = `ESA_IIR_LSR;
        else if (ie_r)
          code = `ESA_IIR_RDA;
        else if (ie_t)
          code = `ESA_IIR_THR;
        else
          code = `ESA_IIR_NONE;
      end
      // register read mux
      always @*
      begin
        case (i_addr)
          `ESA_REG_DATA: rdata = dlab ? div_ff[7:0] : rxm_ff[rrp_ff];
          `ESA_REG_IER: rdata = dlab ? div_ff[15:8] : {4'h0, ier_ff};
          `ESA_REG_IIR: rdata = {{2{fen_ff}}, 2'h0, code};
          `ESA_REG_LCR: rdata = lcr_ff;
          `ESA_REG_MCR: rdata = {3'h0, mcr_ff};
          `ESA_REG_LSR: rdata = {1'b0, (tcnt_ff == 0) & (tst_ff == 3'h0),
            tcnt_ff == 0, err_ff[3], err_ff[2], err_ff[1], err_ff[0], rcnt_ff != 0};
          `ESA_REG_SCR: rdata = scr_ff;
          default: rdata = 8'h00;
        endcase
      end
      assign o_rdata[8*c+7:8*c] = rdata;
      assign o_pend[c] = ie_l | ie_r | ie_t;
      assign o_code[4*c+3:4*c] = code;
      assign o_txd[c] = txd_ff;
      // fifo storage, written only on accepted pushes
      always @(posedge i_clk)
      begin
        if (i_ce & push_t)
          txm_ff[twp_ff] <= i_wdata;
        if (i_ce & rx_done & !rfull)
          rxm_ff[rwp_ff] <= rdat;
      end
      // registers, baud divider, transmitter and receiver
      always @(posedge i_clk)
      begin
        if (i_srst)
        begin
          lcr_ff <= `ESA_LCR_RST;
          mcr_ff <= `ESA_MCR_RST;
          div_ff <= `ESA_DIV_RST;
          bcnt_ff <= 16'h0000;
          scr_ff <= 8'h00;
          ier_ff <= 4'h0;
          err_ff <= 4'h0;
          fen_ff <= 1'b0;
          twp_ff <= {AW{1'b0}};
          trp_ff <= {AW{1'b0}};
          rwp_ff <= {AW{1'b0}};
          rrp_ff <= {AW{1'b0}};
          tcnt_ff <= {(AW+1){1'b0}};
          rcnt_ff <= {(AW+1){1'b0}};
          tst_ff <= 3'h0;
          rxs_ff <= 3'h0;
          tsub_ff <= 6'h00;
          rsub_ff <= 6'h00;
          tbit_ff <= 3'h0;
          rbit_ff <= 3'h0;
          tsh_ff <= 8'h00;
          rsh_ff <= 8'h00;
          tl_ff <= 1'b1;
          tpar_ff <= 1'b0;
          txd_ff <= 1'b1;
          rs1_ff <= 1'b1;
          rs2_ff <= 1'b1;
          rpe_ff <= 1'b0;
          rpb_ff <= 1'b0;
        end
        else if (i_ce)
        begin
          rs1_ff <= i_rxd[c];
          rs2_ff <= rs1_ff;
          txd_ff <= tl_ff ^ ~mcr_ff[`ESA_MCR_POL];
          // host writes
          if (wr)
          begin
            case (i_addr)
              `ESA_REG_DATA: if (dlab) div_ff[7:0] <= i_wdata;
              `ESA_REG_IER: if (dlab) div_ff[15:8] <= i_wdata; else ier_ff <= i_wdata[3:0];
              `ESA_REG_IIR: fen_ff <= i_wdata[0];
              `ESA_REG_LCR: lcr_ff <= i_wdata;
              `ESA_REG_MCR: mcr_ff <= i_wdata[4:0];
              `ESA_REG_SCR: scr_ff <= i_wdata;
              default: scr_ff <= scr_ff;
            endcase
          end
          // baud divider on the 12.288 MHz reference ticks, 16 ticks a bit
          if (i_ref_tick)
            bcnt_ff <= (bcnt_ff == 16'h0000) ? div_ff - 16'h0001 : bcnt_ff - 16'h0001;
          // error flags: a new error wins over the read that clears
          err_ff <= (lsr_rd ? 4'h0 : err_ff) | eset;
          // transmit fifo bookkeeping
          if (fcr_wr & i_wdata[2])
          begin
            twp_ff <= {AW{1'b0}};
            trp_ff <= {AW{1'b0}};
            tcnt_ff <= {(AW+1){1'b0}};
          end
          else
          begin
            if (push_t)
              twp_ff <= twp_ff + 1'b1;
            if (tx_go)
              trp_ff <= trp_ff + 1'b1;
            tcnt_ff <= tcnt_ff + {{AW{1'b0}}, push_t} - {{AW{1'b0}}, tx_go};
          end
          // receive fifo bookkeeping; a full fifo drops the character
          if (fcr_wr & i_wdata[1])
          begin
            rwp_ff <= {AW{1'b0}};
            rrp_ff <= {AW{1'b0}};
            rcnt_ff <= {(AW+1){1'b0}};
          end
          else
          begin
            if (rx_done & !rfull)
              rwp_ff <= rwp_ff + 1'b1;
            if (pop_r)
              rrp_ff <= rrp_ff + 1'b1;
            rcnt_ff <= rcnt_ff + {{AW{1'b0}}, rx_done & !rfull} - {{AW{1'b0}}, pop_r};
          end
          // transmitter: idle, start, data, parity, stop
          if (tick)
          begin
            if (tst_ff == 3'h0)
            begin
              tl_ff <= !tx_go;
              if (tx_go)
              begin
                tsh_ff <= tword;
                tpar_ff <= tpar;
                tsub_ff <= 6'h0f;
                tst_ff <= 3'h1;
              end
            end
            else if (tsub_ff != 6'h00)
              tsub_ff <= tsub_ff - 6'h01;
            else
            begin
              tsub_ff <= 6'h0f;
              case (tst_ff)
                3'h1:
                begin
                  tst_ff <= 3'h2;
                  tbit_ff <= 3'h0;
                  tl_ff <= tsh_ff[0];
                end
                3'h2:
                begin
                  tsh_ff <= tsh_ff >> 1;
                  tbit_ff <= tbit_ff + 3'h1;
                  if (tbit_ff != nlast)
                    tl_ff <= tsh_ff[1];
                  else if (lcr_ff[`ESA_LCR_PEN])
                  begin
                    tst_ff <= 3'h3;
                    tl_ff <= tpar_ff;
                  end
                  else
                  begin
                    tst_ff <= 3'h4;
                    tl_ff <= 1'b1;
                    tsub_ff <= stopt - 6'h01;
                  end
                end
                3'h3:
                begin
                  tst_ff <= 3'h4;
                  tl_ff <= 1'b1;
                  tsub_ff <= stopt - 6'h01;
                end
                default: tst_ff <= 3'h0;
              endcase
            end
          end
          // receiver: hunt, start, data, parity, stop, wait for mark
          if (rxs_ff == 3'h0)
          begin
            if (!rl)
            begin
              rxs_ff <= 3'h1;
              rsub_ff <= 6'h07;
            end
          end
          else if (tick)
          begin
            if (rsub_ff != 6'h00)
              rsub_ff <= rsub_ff - 6'h01;
            else
            begin
              rsub_ff <= 6'h0f;
              case (rxs_ff)
                3'h1:
                begin
                  rxs_ff <= rl ? 3'h0 : 3'h2;
                  rbit_ff <= 3'h0;
                  rpe_ff <= 1'b0;
                  rpb_ff <= 1'b0;
                end
                3'h2:
                begin
                  rsh_ff <= {rl, rsh_ff[7:1]};
                  rbit_ff <= rbit_ff + 3'h1;
                  if (rbit_ff == nlast)
                    rxs_ff <= lcr_ff[`ESA_LCR_PEN] ? 3'h3 : 3'h4;
                end
                3'h3:
                begin
                  rpb_ff <= rl;
                  rpe_ff <= rl ^ rpar;
                  rxs_ff <= 3'h4;
                end
                3'h4: rxs_ff <= rl ? 3'h0 : 3'h5; // hunt again from mid stop
                default: rxs_ff <= rl ? 3'h0 : 3'h5;
              endcase
            end
          end
        end
      end
    end
  endgenerate
endmodule

module esa_adapter #(
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  input wire i_cs,
  input wire [2:0] i_port,
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire [15:0] i_arb_addr,
  input wire i_arb_rd,
  output reg [15:0] o_arb_data,
  input wire i_setup_wr,
  input wire [3:0] i_setup_data,
  input wire [2:0] i_adapter_id,
  input wire [7:0] i_rxd,
  output wire [7:0] o_txd,
  output reg [7:0] o_irq_out,
  output reg [7:0] o_irq_oe
);
  wire [63:0] rdata;
  wire [7:0] pend;
  wire [31:0] code;
  wire [7:0] sel = {7'h00, i_cs} << i_port;
  reg [14:0] acc_ff;
  // accumulator sum one bit wider so the carry out is never lost
  wire [15:0] acc_sum = {1'b0, acc_ff} + {1'b0, `ESA_REF_KHZ};
  wire [15:0] acc_wrap = acc_sum - {1'b0, `ESA_CLK_KHZ};
  reg ref_ff;
  reg [3:0] setup_ff;
  reg [2:0] id1_ff, id2_ff;
  reg [15:0] arb_ff;
  reg [2:0] win;
  integer i;
  genvar d;
  // four dual controllers make ports 0 to 7
  generate
    for (d = 0; d < 4; d = d + 1)
    begin : g_dual_serial_controller
      esa_dual_ctl #(.AW(AW)) u_dual (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_ref_tick(ref_ff),
        .i_sel(sel[2*d+1:2*d]),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .i_rxd(i_rxd[2*d+1:2*d]),
        .o_txd(o_txd[2*d+1:2*d]),
        .o_rdata(rdata[16*d+15:16*d]),
        .o_pend(pend[2*d+1:2*d]),
        .o_code(code[8*d+7:8*d])
      );
    end
  endgenerate
  // lowest pending port number wins
  always @*
  begin
    win = 3'h0;
    for (i = 7; i >= 0; i = i - 1)
      if (pend[i])
        win = i[2:0];
  end
  // reference tick generator, fractional step, setup and arbitration state
  always @(posedge i_clk)
  begin
    if (i_srst)
    begin
      acc_ff <= 15'h0000;
      ref_ff <= 1'b0;
      setup_ff <= 4'h0;
      id1_ff <= 3'h0;
      id2_ff <= 3'h0;
      arb_ff <= 16'h0000;
      o_rdata <= 8'h00;
      o_arb_data <= 16'h0000;
      o_irq_out <= 8'h00;
      o_irq_oe <= 8'h00;
    end
    else if (i_ce)
    begin
      if (acc_sum >= {1'b0, `ESA_CLK_KHZ})
      begin
        acc_ff <= acc_wrap[14:0];
        ref_ff <= 1'b1;
      end
      else
      begin
        acc_ff <= acc_sum[14:0];
        ref_ff <= 1'b0;
      end
      id1_ff <= i_adapter_id;
      id2_ff <= id1_ff;
      if (i_setup_wr)
        setup_ff <= i_setup_data;
      arb_ff <= {|pend, 1'b0, id2_ff, 1'b0, win, 3'h0, code[4*win+:4]};
      if (i_arb_rd & (i_arb_addr == `ESA_ARB_ADDR))
        o_arb_data <= arb_ff;
      if (i_rd & i_cs)
        o_rdata <= rdata[8*i_port+:8];
      o_irq_out <= 8'h00;
      o_irq_oe <= ({7'h00, setup_ff[3] & (|pend)} << setup_ff[2:0]);
    end
  end
endmodule
`default_nettype wire

/* test/esa_checker.sv */
// port assertions for the eight-port serial adapter
`timescale 1ns/1ns
`default_nettype none
module esa_checker (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_cs,
  input wire logic i_rd,
  input wire logic [15:0] i_arb_addr,
  input wire logic i_arb_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [15:0] o_arb_data,
  input wire logic [7:0] o_txd,
  input wire logic [7:0] o_irq_out,
  input wire logic [7:0] o_irq_oe
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // accepted arbitration read
  wire arb_take = i_arb_rd && i_ce && (i_arb_addr == 16'h0130);
  // request line, open drain value and layout of the arbitration word
  one_line_a: assert property ($onehot0(o_irq_oe)) else $error("two request lines");
  drain_low_a: assert property (o_irq_out == 8'h00) else $error("request drives high");
  arb_layout_a: assert property (o_arb_data[14] == 1'b0 && o_arb_data[10] == 1'b0
    && o_arb_data[6:4] == 3'h0) else $error("arbitration spare bits set");
  arb_code_a: assert property (o_arb_data[15] |-> o_arb_data[3:0] inside {4'h2, 4'h4, 4'h6})
    else $error("pending word without a cause");
  // read data holds between accepted reads
  arb_hold_a: assert property (!arb_take |=> $stable(o_arb_data))
    else $error("arbitration word changed without read");
  rdata_hold_a: assert property (!(i_rd && i_cs && i_ce) |=> $stable(o_rdata))
    else $error("read data changed without read");
  reset_state_a: assert property ($fell(i_srst) |-> o_txd == 8'hff && o_irq_oe == 8'h00
    && o_arb_data == 16'h0000) else $error("bad state after reset");
  // a serial level lasts at least a fraction of a bit
  bit_hold_a: assert property ($changed(o_txd[2]) |=> $stable(o_txd[2])[*8])
    else $error("serial level too short");
  cover property (arb_take && o_arb_data[15]);
  cover property (o_irq_oe != 8'h00);
  cover property ($fell(o_txd[2]));
endmodule
`default_nettype wire

/* test/esa_term.sv */
// serial terminal model: captures frames from the adapter and sends frames to it
`timescale 1ns/1ns
`default_nettype none
module esa_term #(
  parameter int BIT_NS = 1302
) (
  input wire logic i_line,
  output logic o_line
);
  int rx_len = 9;
  int rx_cnt = 0;
  logic [11:0] rx_word = 12'h000;
  initial o_line = 1'b1;
  // sample mid-bit after a start bit, lsb first, stop bit last
  always
  begin
    @(negedge i_line);
    #(BIT_NS / 2);
    if (i_line == 1'b0)
    begin
      rx_word = 12'h000;
      for (int i = 0; i < rx_len; i++)
      begin
        #(BIT_NS);
        rx_word[i] = i_line;
      end
      rx_cnt++;
    end
  end
  // start bit, n bits lsb first, one stop bit, then idle at mark
  task automatic send(input logic [9:0] bits, input int n);
    #3; // step off the clock edge before the line moves
    o_line = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < n; i++)
    begin
      o_line = bits[i];
      #(BIT_NS);
    end
    o_line = 1'b1;
    #(BIT_NS);
  endtask
endmodule
`default_nettype wire

/* test/tb_esa_adapter.sv */
// self-checking bench for the eight-port serial adapter
`include "esa_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tb_esa_adapter;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_cs = 1'b0;
  logic [2:0] i_port = 3'h0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_arb_addr = 16'h0000;
  logic i_arb_rd = 1'b0;
  logic i_setup_wr = 1'b0;
  logic [3:0] i_setup_data = 4'h0;
  logic [2:0] i_adapter_id = 3'h5;
  wire [7:0] o_rdata;
  wire [15:0] o_arb_data;
  wire [7:0] o_txd;
  wire [7:0] o_irq_out;
  wire [7:0] o_irq_oe;
  wire term_line;
  wire [7:0] rxd = {2'b11, term_line, 5'h1f}; // idle ports rest at mark
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int n, c0, wt;
  logic [7:0] rv;
  logic [15:0] av, ew;
  logic [7:0] fmt [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h1b, 8'h0b};
  esa_adapter uut (.i_clk(i_clk), .i_srst(i_srst), .i_ce(1'b1), .i_cs(i_cs), .i_port(i_port),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_arb_addr(i_arb_addr), .i_arb_rd(i_arb_rd), .o_arb_data(o_arb_data),
    .i_setup_wr(i_setup_wr), .i_setup_data(i_setup_data), .i_adapter_id(i_adapter_id),
    .i_rxd(rxd), .o_txd(o_txd), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe));
  esa_term term (.i_line(o_txd[2]), .o_line(term_line));
  // 25 MHz clock
  initial
  begin
    forever #20 i_clk = ~i_clk;
  end
  // channel register write, one strobe cycle
  task automatic wr(input logic [2:0] p, input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_cs <= 1'b1;
    i_wr <= 1'b1;
    i_port <= p;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_cs <= 1'b0;
    i_wr <= 1'b0;
  endtask
  // channel register read, data settled after the taking edge
  task automatic rd(input logic [2:0] p, input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_cs <= 1'b1;
    i_rd <= 1'b1;
    i_port <= p;
    i_addr <= a;
    @(posedge i_clk);
    i_cs <= 1'b0;
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // arbitration word read
  task automatic arb(input logic [15:0] a, output logic [15:0] d);
    @(posedge i_clk);
    i_arb_rd <= 1'b1;
    i_arb_addr <= a;
    @(posedge i_clk);
    i_arb_rd <= 1'b0;
    #1 d = o_arb_data;
  endtask
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      results();
    end
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_srst <= 1'b0;
    @(posedge i_clk);
    #1 chk(o_txd, 8'hff);
    chk(o_irq_oe, 8'h00);
    rd(3'h0, `ESA_REG_LCR, rv);
    chk(rv, 8'h03);
    rd(3'h7, `ESA_REG_MCR, rv);
    chk(rv, 8'h08);
    $display("test reset done");
    // every length and parity kind out of port 2, frame captured by the terminal
    foreach (fmt[k])
    begin
      n = (fmt[k] & 3) + 5;
      ew = 16'h00a7 & ((16'h1 << n) - 16'h1);
      if (fmt[k][3])
      begin
        ew[n] = fmt[k][4] ? ^ew : ~^ew;
        n++;
      end
      ew[n] = 1'b1;
      term.rx_len = n + 1;
      wr(3'h2, `ESA_REG_LCR, fmt[k]);
      c0 = term.rx_cnt;
      wr(3'h2, `ESA_REG_DATA, 8'ha7);
      wt = 0;
      while (term.rx_cnt == c0 && wt < 3000)
      begin
        @(posedge i_clk);
        wt++;
      end
      repeat (80) @(posedge i_clk);
      chk(16'(term.rx_word), ew);
    end
    $display("test transmit done");
    // seven bits even parity into port 5, good then bad parity
    wr(3'h5, `ESA_REG_LCR, 8'h1a);
    term.send({2'b00, ^7'h5a, 7'h5a}, 8);
    repeat (8) @(posedge i_clk);
    rd(3'h5, `ESA_REG_LSR, rv);
    chk(rv & 8'h1f, 8'h01);
    rd(3'h5, `ESA_REG_DATA, rv);
    chk(rv, 8'h5a);
    term.send({2'b00, ~^7'h5a, 7'h5a}, 8);
    repeat (8) @(posedge i_clk);
    rd(3'h5, `ESA_REG_LSR, rv);
    chk(rv & 8'h05, 8'h05);
    rd(3'h5, `ESA_REG_LSR, rv);
    chk(rv & 8'h04, 8'h00);
    rd(3'h5, `ESA_REG_DATA, rv);
    $display("test receive done");
    // back to back characters: fifo mode keeps both, a single holding place overruns
    wr(3'h5, `ESA_REG_IIR, 8'h01);
    term.send({2'b00, ^7'h21, 7'h21}, 8);
    term.send({2'b00, ^7'h42, 7'h42}, 8);
    repeat (8) @(posedge i_clk);
    rd(3'h5, `ESA_REG_DATA, rv);
    chk(rv, 8'h21);
    rd(3'h5, `ESA_REG_DATA, rv);
    chk(rv, 8'h42);
    wr(3'h5, `ESA_REG_IIR, 8'h00);
    term.send({2'b00, ^7'h21, 7'h21}, 8);
    term.send({2'b00, ^7'h42, 7'h42}, 8);
    repeat (8) @(posedge i_clk);
    rd(3'h5, `ESA_REG_LSR, rv);
    chk(rv & 8'h1f, 8'h03);
    rd(3'h5, `ESA_REG_DATA, rv);
    chk(rv, 8'h21);
    $display("test fifo done");
    // inverted polarity idles at space
    wr(3'h1, `ESA_REG_MCR, 8'h00);
    repeat (4) @(posedge i_clk);
    #1 chk(o_txd[1], 1'b0);
    wr(3'h1, `ESA_REG_MCR, 8'h08);
    repeat (4) @(posedge i_clk);
    #1 chk(o_txd[1], 1'b1);
    $display("test polarity done");
    // two ports pending, lowest port reported, line 3 pulled
    wr(3'h6, `ESA_REG_IER, 8'h02);
    wr(3'h4, `ESA_REG_IER, 8'h02);
    @(posedge i_clk);
    i_setup_wr <= 1'b1;
    i_setup_data <= 4'hb;
    @(posedge i_clk);
    i_setup_wr <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1 chk(o_irq_oe, 8'h08);
    arb(16'h0130, av);
    chk(av, {1'b1, 1'b0, 3'h5, 1'b0, 3'h4, 3'h0, `ESA_IIR_THR});
    arb(16'h0131, av);
    chk(av, {1'b1, 1'b0, 3'h5, 1'b0, 3'h4, 3'h0, `ESA_IIR_THR});
    wr(3'h4, `ESA_REG_IER, 8'h00);
    repeat (4) @(posedge i_clk);
    arb(16'h0130, av);
    chk(av, {1'b1, 1'b0, 3'h5, 1'b0, 3'h6, 3'h0, `ESA_IIR_THR});
    wr(3'h6, `ESA_REG_IER, 8'h00);
    repeat (4) @(posedge i_clk);
    #1 chk(o_irq_oe, 8'h00);
    arb(16'h0130, av);
    chk(av[15], 1'b0);
    $display("test interrupt done");
    results();
  end
endmodule
bind esa_adapter esa_checker chk_i (.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_cs(i_cs),
  .i_rd(i_rd), .i_arb_addr(i_arb_addr), .i_arb_rd(i_arb_rd), .o_rdata(o_rdata),
  .o_arb_data(o_arb_data), .o_txd(o_txd), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe));
`default_nettype wire
